//--- design/sps_top.sv
// soft power supervisor: power switch, host handshake, supply enables, rail and thermal faults
// assumes all inputs except clock and rst are asynchronous pins; runs from an always-present supply
`timescale 1ns/1ns
`include "sps_regs.svh"
module sps_top
  import sps_pkg::*;
#(
  parameter longint REQ_CYCLES   = `SPS_REQ_TIMEOUT_S * `SPS_CLK_HZ,
  parameter longint BLANK_CYCLES = `SPS_UV_BLANK_S * `SPS_CLK_HZ,
  parameter longint CLEAR_CYCLES = `SPS_FAULT_CLR_S * `SPS_CLK_HZ
) (
  input  wire logic                         clock,
  input  wire logic                         rst,
  input  wire logic                         powerSwitch,
  input  wire logic                         cpuSupplyCtl,
  input  wire logic [`SPS_RAIL_COUNT-1:0]   railOk,
  input  wire logic                         overTemp,
  input  wire logic                         mainsPresent,
  output logic                              wakeReq,
  output logic                              downReq,
  output logic                              overTempNotify,
  output logic [`SPS_SUPPLY_COUNT-1:0]      supplyOn,
  output logic                              uvFault,
  output logic                              otFault
);
  // state and decoded helpers
  sps_state_s s_ff;   // registered state
  sps_state_s nxt_s;  // next state
  logic       cpuOn;  // host holds supplies on
  logic       press;  // switch press edge
  logic       uvTrip; // armed monitor sees a low rail
  logic       faults; // any latched fault

  // one handshake bundle per interval timer
  sps_tmr_if reqIf ();    // host response timeout
  sps_tmr_if blankIf ();  // monitor blanking after power-up
  sps_tmr_if clearIf ();  // mains absence for fault clear

  // request timeout runs while a request is outstanding
  assign reqIf.run   = (s_ff.state == ST_WAKE_WAIT) || (s_ff.state == ST_DOWN_WAIT);
  assign blankIf.run = s_ff.supplyOn[0];
  assign clearIf.run = ~s_ff.mainsSync[1];

  // each timer restarts whenever its run line drops
  sps_timer #(.LIMIT(REQ_CYCLES))   u_req   (.clock(clock), .rst(rst), .tmr(reqIf));
  sps_timer #(.LIMIT(BLANK_CYCLES)) u_blank (.clock(clock), .rst(rst), .tmr(blankIf));
  sps_timer #(.LIMIT(CLEAR_CYCLES)) u_clear (.clock(clock), .rst(rst), .tmr(clearIf));

  // decoded views of the synchronised inputs
  assign cpuOn  = s_ff.cpuSync[1];
  assign press  = s_ff.swSync[1] & ~s_ff.swPrev;
  assign uvTrip = blankIf.expired & s_ff.supplyOn[0] & ~(&s_ff.railSync1); // R8
  assign faults = s_ff.uvFault | s_ff.otFault;

  // sequencing, fault latching and supply control
  always_comb begin
    nxt_s = s_ff;
    // two-stage synchronisers
    nxt_s.swSync    = {s_ff.swSync[0], powerSwitch};
    nxt_s.swPrev    = s_ff.swSync[1];
    nxt_s.cpuSync   = {s_ff.cpuSync[0], cpuSupplyCtl};
    nxt_s.otSync    = {s_ff.otSync[0], overTemp};
    nxt_s.mainsSync = {s_ff.mainsSync[0], mainsPresent};
    // rails synchronised as a bus; only the monitor reads the second stage
    nxt_s.railSync0 = railOk;
    nxt_s.railSync1 = s_ff.railSync0;
    // fault clear after long mains absence; sets below win
    if (clearIf.expired) begin
      nxt_s.uvFault  = 1'b0; // R7
      nxt_s.otFault  = 1'b0; // R7
      nxt_s.otNotify = 1'b0;
    end
    // thermal fault latches even while off
    if (s_ff.otSync[1]) begin
      nxt_s.otFault = 1'b1; // R7
    end
    case (s_ff.state)
      ST_OFF: begin
        // press while off asks the host to wake
        if (press && !faults) begin
          nxt_s.state   = ST_WAKE_WAIT;
          nxt_s.wakeReq = 1'b1; // R1
        end
      end
      ST_WAKE_WAIT: begin
        // host answer ends the wait, silence ends it by timeout
        if (cpuOn) begin
          nxt_s.state   = ST_ON; // R10
          nxt_s.wakeReq = 1'b0;
        end else if (reqIf.expired) begin
          nxt_s.state   = ST_OFF; // R3
          nxt_s.wakeReq = 1'b0;
        end
      end
      ST_ON: begin
        if (!cpuOn) begin
          // host powered down on its own
          nxt_s.state = ST_OFF;
        end else if (s_ff.otSync[1] && !s_ff.otNotify) begin
          // first thermal warning of this fault episode
          nxt_s.state    = ST_DOWN_WAIT;
          nxt_s.otNotify = 1'b1; // R5
        end else if (press) begin
          // press while on asks for a power-down
          nxt_s.state   = ST_DOWN_WAIT;
          nxt_s.downReq = 1'b1; // R1
        end
      end
      ST_DOWN_WAIT: begin
        // host dropping its line completes the power-down
        if (!cpuOn) begin
          nxt_s.state   = ST_OFF; // R10
          nxt_s.downReq = 1'b0;
        end else if (reqIf.expired) begin
          nxt_s.state   = ST_OFF; // R3 R6
          nxt_s.downReq = 1'b0;
        end
      end
      default: begin
        // illegal code recovers to off
        nxt_s.state = ST_OFF;
      end
    endcase
    // under-voltage overrides everything, no host involvement
    if (uvTrip) begin
      nxt_s.uvFault = 1'b1; // R4 R7
      nxt_s.state   = ST_OFF;
      nxt_s.wakeReq = 1'b0;
      nxt_s.downReq = 1'b0;
    end
    // supplies follow the host line only while sequencing allows it
    nxt_s.supplyOn = {`SPS_SUPPLY_COUNT{cpuOn && !nxt_s.uvFault &&
                      (nxt_s.state == ST_ON || nxt_s.state == ST_DOWN_WAIT)}}; // R2 R9
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff       <= '0;
      s_ff.state <= ST_OFF;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // outputs straight from flops
  assign wakeReq        = s_ff.wakeReq;
  assign downReq        = s_ff.downReq;
  assign overTempNotify = s_ff.otNotify;
  assign supplyOn       = s_ff.supplyOn;
  assign uvFault        = s_ff.uvFault;
  assign otFault        = s_ff.otFault;

  // all checks sample on the supervisor clock and sleep during reset
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  // a press while off and fault-free raises the wake request
  a_wake_press: assert property ((s_ff.state == ST_OFF && press && !faults && !uvTrip) |=> wakeReq) // R1
    else $error("press while off did not raise wake request");
  // a press while on raises the power-down request unless a warning takes priority
  a_down_press: assert property ((s_ff.state == ST_ON && cpuOn && press && !uvTrip && !(s_ff.otSync[1] && !s_ff.otNotify))
    |=> downReq) // R1
    else $error("press while on did not raise power-down request");
  // supplies are only on while the host line was on
  a_supply_host: assert property (supplyOn[0] |-> $past(cpuOn)) // R2
    else $error("supplies on without host control line");
  // an unanswered power-down ends in a forced off
  a_req_timeout: assert property ((s_ff.state == ST_DOWN_WAIT && reqIf.expired && cpuOn)
    |=> (s_ff.state == ST_OFF && supplyOn == '0)) // R3
    else $error("timeout did not force supplies off");
  // an under-voltage trip drops both supplies in the same cycle
  a_uv_shutdown: assert property ($rose(uvFault) |-> supplyOn == '0) // R4
    else $error("under-voltage did not shut supplies");
  // a thermal warning is raised once and starts the power-down wait
  a_ot_notify: assert property ((s_ff.state == ST_ON && cpuOn && s_ff.otSync[1] && !s_ff.otNotify && !uvTrip)
    |=> (overTempNotify && s_ff.state == ST_DOWN_WAIT)) // R5
    else $error("over-temperature not notified");
  // an unanswered thermal warning ends in a forced off
  a_ot_force: assert property ((overTempNotify && s_ff.state == ST_DOWN_WAIT && reqIf.expired)
    |=> !supplyOn[0] ##1 !supplyOn[1]) // R6
    else $error("over-temperature timeout did not force off");
  // the under-voltage latch holds until the mains absence timer runs out
  a_fault_hold: assert property ((uvFault && !clearIf.expired) |=> uvFault) // R7
    else $error("under-voltage fault lost without mains absence");
  // a long mains absence clears both latches
  a_fault_clear: assert property ((clearIf.expired && !s_ff.otSync[1] && !uvTrip) |=> (!uvFault && !otFault)) // R7
    else $error("faults not cleared after mains absence");
  // no under-voltage trip while the monitor is blanked
  a_uv_blank: assert property (!blankIf.expired |=> !$rose(uvFault)) // R8
    else $error("under-voltage flagged during blanking");
  // both supply enables always move together
  a_supply_pair: assert property (supplyOn[0] == supplyOn[1]) // R9
    else $error("supply enables disagree");
  // the host finishing a power-down cancels the wait
  a_req_cancel: assert property ((s_ff.state == ST_DOWN_WAIT && !cpuOn) |=> (s_ff.state == ST_OFF && !downReq)) // R10
    else $error("completed power-down did not cancel timeout");

  // scenario coverage
  c_wake_done: cover property (wakeReq ##[1:1000] supplyOn[0]);
  c_forced_off: cover property (s_ff.state == ST_DOWN_WAIT && reqIf.expired);
  c_uv_trip: cover property ($rose(uvFault));
  c_ot_soft: cover property (overTempNotify && s_ff.state == ST_DOWN_WAIT && !cpuOn);
  c_blank_dip: cover property (supplyOn[0] && !blankIf.expired && !(&s_ff.railSync1));
endmodule

//--- include/sps_regs.svh
// constants for the soft power supervisor: timing figures and widths
// assumes a single 25 MHz clock; derived cycle counts are formed in the top module
// Summary of operation
// R1: switch press asks host to wake or power down
// R2: host drives the supply control line
// R3: no host response: force supplies off after 2 min
// R4: any of six rails under 90%: immediate shutdown
// R5: over-temperature notifies the host
// R6: over-temperature: force off after 2 min
// R7: faults latch; clear after 15 s mains absence
// R8: under-voltage monitor blanked 1 s after power-up
// R9: supplies switched by dedicated on/off outputs
// R10: host completing transition cancels the timeout
`ifndef SPS_REGS_SVH
`define SPS_REGS_SVH
`define SPS_CLK_HZ         64'd25000000
`define SPS_REQ_TIMEOUT_S  64'd120
`define SPS_UV_BLANK_S     64'd1
`define SPS_FAULT_CLR_S    64'd15
`define SPS_RAIL_COUNT     6
`define SPS_SUPPLY_COUNT   2
`define SPS_TMR_WIDTH      32
`endif

//--- include/sps_pkg.sv
// types shared by the soft power supervisor modules
// assumes sps_regs.svh is on the include path
`include "sps_regs.svh"
package sps_pkg;
  // power sequencing states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_WAKE_WAIT,
    ST_ON,
    ST_DOWN_WAIT
  } sps_state_e;

  // complete state of the top module
  typedef struct packed {
    sps_state_e                         state;
    logic [1:0]                         swSync;
    logic                               swPrev;
    logic [1:0]                         cpuSync;
    logic [1:0]                         otSync;
    logic [1:0]                         mainsSync;
    logic [`SPS_RAIL_COUNT-1:0]         railSync0;
    logic [`SPS_RAIL_COUNT-1:0]         railSync1;
    logic                               wakeReq;
    logic                               downReq;
    logic                               otNotify;
    logic                               uvFault;
    logic                               otFault;
    logic [`SPS_SUPPLY_COUNT-1:0]       supplyOn;
  } sps_state_s;

  // complete state of one interval timer
  typedef struct packed {
    logic [`SPS_TMR_WIDTH-1:0] cnt;
    logic                      done;
  } sps_tmr_s;
endpackage

//--- include/sps_tmr_if.sv
// handshake between the supervisor and one interval timer
// assumes both ends share the supervisor clock
`timescale 1ns/1ns
interface sps_tmr_if;
  logic run;      // count while high, restart when low
  logic expired;  // interval elapsed while run stayed high
  modport owner (output run, input expired);
  modport timer (input run, output expired);
endinterface

//--- design/sps_timer.sv
// interval timer: expired rises once run has been high for LIMIT cycles
// assumes run comes from logic on the same clock
`timescale 1ns/1ns
`include "sps_regs.svh"
module sps_timer
  import sps_pkg::*;
#(
  parameter int          WIDTH = `SPS_TMR_WIDTH,
  parameter longint      LIMIT = 64'd1
) (
  input  wire logic      clock,
  input  wire logic      rst,
  sps_tmr_if.timer       tmr
);
  sps_tmr_s s_ff;   // registered state
  sps_tmr_s nxt_s;  // next state

  // count up while run holds, hold done at the end
  always_comb begin
    nxt_s = s_ff;
    if (!tmr.run) begin
      nxt_s.cnt  = '0;
      nxt_s.done = 1'b0;
    end else if (s_ff.cnt == WIDTH'(LIMIT - 64'd1)) begin
      nxt_s.done = 1'b1;
    end else begin
      nxt_s.cnt = s_ff.cnt + WIDTH'(1);
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign tmr.expired = s_ff.done;
endmodule

//--- tb/sps_host_model.sv
// host side model: answers wake and power-down requests on the supply control line
// assumes the supervisor clock; mute makes the host ignore requests
`timescale 1ns/1ns
module sps_host_model #(
  parameter int DELAY = 3   // falling edges the host counts before it answers on the next one
) (
  input  wire logic       clock,
  input  wire logic       rst,
  input  wire logic       wakeReq,
  input  wire logic       downReq,
  input  wire logic [1:0] supplyOn,
  input  wire logic       mute,
  input  wire logic       overTempNotify,
  output logic            cpuSupplyCtl
);
  int waitCnt;  // answer delay counter
  initial cpuSupplyCtl = 1'b0;
  // host drives its line just after the falling edge
  always @(negedge clock) begin
    if (rst) begin
      cpuSupplyCtl <= 1'b0;
      waitCnt      <= 0;
    end else if (supplyOn == 2'h0 && !wakeReq) begin
      // host unpowered: line drops
      cpuSupplyCtl <= 1'b0;
      waitCnt      <= 0;
    end else if (!mute && (wakeReq || downReq || overTempNotify)) begin
      if (waitCnt == DELAY) begin
        cpuSupplyCtl <= wakeReq;
        waitCnt      <= 0;
      end else begin
        waitCnt <= waitCnt + 1;
      end
    end else begin
      waitCnt <= 0;
    end
  end
endmodule

//--- tb/test_sps_top.sv
// testbench for the soft power supervisor with a host model
// assumes short sim counts: request 50, blanking 20, fault clear 30 cycles
`timescale 1ns/1ns
`include "sps_regs.svh"
module test_sps_top
  import sps_pkg::*;
;
  localparam int REQ = 50;
  localparam int BLANK = 20;
  localparam int CLR = 30;
  logic       clock = 1'b0;
  logic       rst = 1'b1;
  logic       powerSwitch = 1'b0;
  logic       cpuSupplyCtl;
  logic [5:0] railOk = 6'h3F;
  logic       overTemp = 1'b0;
  logic       mainsPresent = 1'b1;
  logic       mute = 1'b0;
  logic       wakeReq, downReq, overTempNotify, uvFault, otFault;
  logic [1:0] supplyOn;
  int         errors = 0;
  int         num_checks = 0;
  sps_top #(.REQ_CYCLES(REQ), .BLANK_CYCLES(BLANK), .CLEAR_CYCLES(CLR)) dut (.clock(clock), .rst(rst),
    .powerSwitch(powerSwitch), .cpuSupplyCtl(cpuSupplyCtl), .railOk(railOk), .overTemp(overTemp),
    .mainsPresent(mainsPresent), .wakeReq(wakeReq), .downReq(downReq), .overTempNotify(overTempNotify),
    .supplyOn(supplyOn), .uvFault(uvFault), .otFault(otFault));
  sps_host_model host (.clock(clock), .rst(rst), .wakeReq(wakeReq), .downReq(downReq),
    .supplyOn(supplyOn), .mute(mute), .overTempNotify(overTempNotify), .cpuSupplyCtl(cpuSupplyCtl));
  // 25 MHz clock
  initial begin
    forever #20 clock = ~clock;
  end
  // compare and count
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one switch press, held for six cycles
  task automatic press();
    powerSwitch = 1'b1;
    cyc(6);
    powerSwitch = 1'b0;
  endtask
  // mains removed long enough to clear latched faults
  task automatic unplug();
    mainsPresent = 1'b0;
    cyc(CLR - 10);
    chk(supplyOn, 2'h0, "supplies on while faulted");
    chk(8'(uvFault | otFault), 8'h01, "fault cleared early");
    cyc(20);
    mainsPresent = 1'b1;
    chk({uvFault, otFault}, 2'h0, "fault not cleared");
  endtask
  task automatic t_wake_down();
    press();
    chk(wakeReq, 1'b1, "wake request");
    cyc(9);
    chk({wakeReq, supplyOn}, 3'h3, "supplies on");
    press();
    chk(downReq, 1'b1, "down request");
    cyc(9);
    chk({downReq, supplyOn}, 3'h0, "supplies off");
  endtask
  task automatic t_timeouts();
    mute = 1'b1;
    press();
    cyc(REQ - 16);
    chk(wakeReq, 1'b1, "wake dropped early");
    cyc(26);
    chk({wakeReq, supplyOn}, 3'h0, "wake timeout");
    mute = 1'b0;
    press();
    cyc(9);
    mute = 1'b1;
    press();
    cyc(REQ - 16);
    chk({downReq, supplyOn}, 3'h7, "down ended early");
    cyc(26);
    chk({downReq, supplyOn}, 3'h0, "forced off");
    mute = 1'b0;
  endtask
  task automatic t_overtemp();
    press();
    cyc(9);
    mute = 1'b1;
    overTemp = 1'b1;
    cyc(6);
    chk({overTempNotify, downReq}, 2'h2, "thermal notify");
    overTemp = 1'b0;
    cyc(REQ + 6);
    chk({supplyOn, otFault}, 3'h1, "thermal forced off");
    mute = 1'b0;
    press();
    cyc(3);
    chk(wakeReq, 1'b0, "press while faulted");
    unplug();
  endtask
  // host answers a thermal warning with its own power-down
  task automatic t_ot_soft();
    press();
    cyc(9);
    overTemp = 1'b1;
    cyc(6);
    chk({overTempNotify, supplyOn}, 3'h7, "thermal notify host on");
    overTemp = 1'b0;
    cyc(4);
    chk({overTempNotify, supplyOn, otFault}, 4'h9, "host down after warning");
    unplug();
  endtask
  task automatic t_rails();
    for (int i = 0; i < 6; i++) begin
      press();
      cyc(9);
      railOk[i] = 1'b0;
      cyc(4);
      railOk[i] = 1'b1;
      chk({supplyOn, uvFault}, 3'h6, "rail dip in blanking");
      cyc(BLANK);
      railOk[i] = 1'b0;
      cyc(5);
      railOk[i] = 1'b1;
      chk({supplyOn, uvFault}, 3'h1, "under voltage trip");
      unplug();
    end
  endtask
  task automatic test_done();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // watchdog well beyond the expected run
  initial begin
    repeat (3000) @(posedge clock);
    errors++;
    test_done();
  end
  initial begin
    repeat (20) @(negedge clock);
    rst = 1'b0;
    cyc(2);
    chk({wakeReq, downReq, supplyOn, uvFault, otFault}, 6'h00, "reset outputs");
    t_wake_down();
    t_timeouts();
    t_overtemp();
    t_ot_soft();
    t_rails();
    test_done();
  end
endmodule
